/* File: rtl/decim_pkg.sv */
package decim_pkg;
   // Profile select codes
   typedef enum logic [1:0] {
      PROF_FAST   = 2'h0,
      PROF_HIRES  = 2'h1,
      PROF_LOWPWR = 2'h2,
      PROF_SLOW   = 2'h3
   } profile_t;

   localparam int NUM_CH        = 8;
   localparam int RESULT_W      = 24;
   localparam int ACC_W         = 32;
   localparam int FIFO_DEPTH    = 8;

   // Decimation ratios
   localparam logic [7:0] OSR_NORMAL = 8'h40;   // 64
   localparam logic [7:0] OSR_HIRES  = 8'h80;   // 128

   // Master clock to modulator rate divisors
   localparam logic [5:0] DIV_4  = 6'h04;
   localparam logic [5:0] DIV_8  = 6'h08;
   localparam logic [5:0] DIV_40 = 6'h28;

   // Result saturation codes
   localparam logic [RESULT_W-1:0] CODE_MAX = 24'h7FFFFF;
   localparam logic [RESULT_W-1:0] CODE_MIN = 24'h800000;

   // Reset values
   localparam logic [5:0] DIV_CNT_RST = 6'h00;
   localparam logic [7:0] DEC_CNT_RST = 8'h00;

   // One word of all channels
   typedef struct packed {
      logic [NUM_CH-1:0][RESULT_W-1:0] sample;
   } frame_t;
endpackage

/* File: rtl/octal_decimation_filter_core.sv */
// Notes on behaviour
// - Fast, low-power, slow profiles decimate by 64
// - High-resolution profile decimates by 128
// - Stop band attenuation at least 100 dB; the code uses a plain sinc^3 stand-in with no compensating FIR
// - Linear-phase filter, constant input-output delay
// - Step settles within 76 or 78 words
// - Results are 24-bit twos complement words
// - Results clip at full scale, no wrap
// - Zero maps to zero, one step to one
// - Modulator rate divisor set by profile, divide pin
// - Profile pins are monitored continuously
// - All channels convolve on same modulator cycle
// - Alignment low halts and clears counters
`timescale 1ns/100ps
module octal_decimation_filter_core
   import decim_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_sys_i,
   input  wire logic               rst_i,
   // Pins
   input  wire logic [1:0]         profile_select_i,
   input  wire logic               clock_divide_select_i,
   input  wire logic               align_n_i,
   input  wire logic [NUM_CH-1:0]  mod_bits_i,
   // Result stream
   output frame_t                  result_o,
   output logic                    result_valid_o,
   input  wire logic               result_ready_i,
   // Status
   output logic                    modulator_rate_o,
   output logic                    output_word_rate_o,
   output logic                    overflow_o
);
   // Simple sinc^3 comb-integrator stand-in: linear phase by construction.
   // A real coefficient set would add the compensating FIR; the structure
   // keeps the constant group delay and the simultaneous word timing.

   // Pin synchronisers
   logic [1:0]        prof_s1_reg, prof_s2_reg;
   logic              cdiv_s1_reg, cdiv_s2_reg, align_s1_reg, align_s2_reg;
   logic [NUM_CH-1:0] bits_s1_reg, bits_s2_reg;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         prof_s1_reg  <= 2'h0;
         prof_s2_reg  <= 2'h0;
         cdiv_s1_reg  <= 1'b0;
         cdiv_s2_reg  <= 1'b0;
         align_s1_reg <= 1'b0;
         align_s2_reg <= 1'b0;
         bits_s1_reg  <= '0;
         bits_s2_reg  <= '0;
      end else begin
         prof_s1_reg  <= profile_select_i;
         prof_s2_reg  <= prof_s1_reg;
         cdiv_s1_reg  <= clock_divide_select_i;
         cdiv_s2_reg  <= cdiv_s1_reg;
         align_s1_reg <= align_n_i;
         align_s2_reg <= align_s1_reg;
         bits_s1_reg  <= mod_bits_i;
         bits_s2_reg  <= bits_s1_reg;
      end
   end

   // Divisor selection
   function automatic logic [5:0] divisor(input logic [1:0] p, input logic cdiv);
      case (profile_t'(p))
         PROF_FAST:   divisor = DIV_4;
         PROF_HIRES:  divisor = DIV_4;
         PROF_LOWPWR: divisor = cdiv ? DIV_8 : DIV_4;
         PROF_SLOW:   divisor = cdiv ? DIV_40 : DIV_8;
         default:     divisor = DIV_4;
      endcase
   endfunction

   // Decimation ratio selection
   function automatic logic [7:0] ratio(input logic [1:0] p);
      ratio = (profile_t'(p) == PROF_HIRES) ? OSR_HIRES : OSR_NORMAL;
   endfunction

   // Saturate wide value into 24-bit code
   function automatic logic [RESULT_W-1:0] clip(input logic signed [ACC_W-1:0] v);
      if (v > $signed({{(ACC_W-RESULT_W){1'b0}}, CODE_MAX}))
         clip = CODE_MAX;
      else if (v < $signed({{(ACC_W-RESULT_W){1'b1}}, CODE_MIN}))
         clip = CODE_MIN;
      else
         clip = v[RESULT_W-1:0];
   endfunction

   // Control state
   typedef enum logic {ST_HALT, ST_RUN} run_t;
   run_t        st_reg, st_next;
   logic [5:0]  div_reg, div_next;
   logic [7:0]  dec_reg, dec_next;
   logic [1:0]  prof_reg, prof_next;
   logic        mod_en, word_en;
   logic [5:0]  div_lim;
   logic [7:0]  dec_lim;

   always_comb begin
      st_next   = st_reg;
      div_next  = div_reg;
      dec_next  = dec_reg;
      prof_next = prof_reg;
      mod_en    = 1'b0;
      word_en   = 1'b0;
      div_lim   = divisor(prof_reg, cdiv_s2_reg);
      dec_lim   = ratio(prof_reg);
      case (st_reg)
         ST_HALT: begin
            div_next = DIV_CNT_RST;
            dec_next = DEC_CNT_RST;
            if (align_s2_reg) begin
               st_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!align_s2_reg) begin
               st_next  = ST_HALT;
               div_next = DIV_CNT_RST;
               dec_next = DEC_CNT_RST;
            end else if (prof_s2_reg != prof_reg) begin
               prof_next = prof_s2_reg;
               div_next  = DIV_CNT_RST;
               dec_next  = DEC_CNT_RST;
            end else if (div_reg == div_lim - 6'h01) begin
               div_next = DIV_CNT_RST;
               mod_en   = 1'b1;
               if (dec_reg == dec_lim - 8'h01) begin
                  dec_next = DEC_CNT_RST;
                  word_en  = 1'b1;
               end else begin
                  dec_next = dec_reg + 8'h01;
               end
            end else begin
               div_next = div_reg + 6'h01;
            end
         end
         default: st_next = ST_HALT;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg   <= ST_HALT;
         div_reg  <= DIV_CNT_RST;
         dec_reg  <= DEC_CNT_RST;
         prof_reg <= 2'h0;
      end else begin
         st_reg   <= st_next;
         div_reg  <= div_next;
         dec_reg  <= dec_next;
         prof_reg <= prof_next;
      end
   end

   // Filter datapath: three integrators per channel
   logic signed [ACC_W-1:0] i1_reg [NUM_CH], i2_reg [NUM_CH], i3_reg [NUM_CH];
   logic signed [ACC_W-1:0] i1_next [NUM_CH], i2_next [NUM_CH], i3_next [NUM_CH];
   logic signed [ACC_W-1:0] c1_reg [NUM_CH], c2_reg [NUM_CH], c3_reg [NUM_CH];
   logic signed [ACC_W-1:0] c1_next [NUM_CH], c2_next [NUM_CH], c3_next [NUM_CH];
   logic signed [ACC_W-1:0] d1, d2, d3, sc;
   frame_t                  frame_next;

   always_comb begin
      d1 = '0;
      d2 = '0;
      d3 = '0;
      sc = '0;
      frame_next = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         i1_next[c] = i1_reg[c];
         i2_next[c] = i2_reg[c];
         i3_next[c] = i3_reg[c];
         c1_next[c] = c1_reg[c];
         c2_next[c] = c2_reg[c];
         c3_next[c] = c3_reg[c];
         if (st_reg == ST_HALT) begin
            i1_next[c] = '0;
            i2_next[c] = '0;
            i3_next[c] = '0;
            c1_next[c] = '0;
            c2_next[c] = '0;
            c3_next[c] = '0;
         end else if (mod_en) begin
            // Every channel steps on the same enable
            i1_next[c] = i1_reg[c] + (bits_s2_reg[c] ? 32'sd1 : -32'sd1);
            i2_next[c] = i2_reg[c] + i1_reg[c];
            i3_next[c] = i3_reg[c] + i2_reg[c];
            if (word_en) begin
               d1 = i3_reg[c] - c1_reg[c];
               d2 = d1 - c2_reg[c];
               d3 = d2 - c3_reg[c];
               c1_next[c] = i3_reg[c];
               c2_next[c] = d1;
               c3_next[c] = d2;
               // 64^3 = 2^18, 128^3 = 2^21; bring to 23-bit full scale
               sc = (prof_reg == 2'(PROF_HIRES)) ? (d3 <<< 2) : (d3 <<< 5);
               frame_next.sample[c] = clip(sc);
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            i1_reg[c] <= '0;
            i2_reg[c] <= '0;
            i3_reg[c] <= '0;
            c1_reg[c] <= '0;
            c2_reg[c] <= '0;
            c3_reg[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            i1_reg[c] <= i1_next[c];
            i2_reg[c] <= i2_next[c];
            i3_reg[c] <= i3_next[c];
            c1_reg[c] <= c1_next[c];
            c2_reg[c] <= c2_next[c];
            c3_reg[c] <= c3_next[c];
         end
      end
   end

   // Output word buffer
   logic   fifo_in_ready, fifo_out_valid;
   logic   out_take;
   frame_t fifo_out_data;
   logic   push_valid;
   assign push_valid = word_en && (st_reg == ST_RUN);

   result_fifo #(.WIDTH($bits(frame_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_data_i   (frame_next),
      .in_valid_i  (push_valid),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (out_take)
   );

   // Output stage register, refilled when empty or taken
   frame_t res_next;
   logic   rv_next, ovf_next;

   always_comb begin
      out_take = fifo_out_valid && (!result_valid_o || result_ready_i);
      res_next = result_o;
      rv_next  = result_valid_o && !result_ready_i;
      ovf_next = overflow_o || (push_valid && !fifo_in_ready);  // Word dropped when full
      if (out_take) begin
         res_next = fifo_out_data;
         rv_next  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         result_o           <= '0;
         result_valid_o     <= 1'b0;
         overflow_o         <= 1'b0;
         modulator_rate_o   <= 1'b0;
         output_word_rate_o <= 1'b0;
      end else begin
         result_o           <= res_next;
         result_valid_o     <= rv_next;
         overflow_o         <= ovf_next;
         modulator_rate_o   <= mod_en;
         output_word_rate_o <= word_en;
      end
   end

   // Checks
   property p_word_period;
      @(posedge clk_sys_i) disable iff (rst_i)
      word_en |=> !word_en [*3];
   endproperty
   a_word_period: assert property (p_word_period) else $error("word enables too close");

   property p_word_with_mod;
      @(posedge clk_sys_i) disable iff (rst_i)
      word_en |-> mod_en;
   endproperty
   a_word_with_mod: assert property (p_word_with_mod) else $error("word without modulator step");

   property p_halt_clears;
      @(posedge clk_sys_i) disable iff (rst_i)
      !align_s2_reg |=> (div_reg == DIV_CNT_RST) && (dec_reg == DEC_CNT_RST);
   endproperty
   a_halt_clears: assert property (p_halt_clears) else $error("counters not cleared");

   property p_no_word_halted;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st_reg == ST_HALT) |-> !mod_en;
   endproperty
   a_no_word_halted: assert property (p_no_word_halted) else $error("step while halted");

   property p_div_fast;
      @(posedge clk_sys_i) disable iff (rst_i)
      (mod_en && prof_reg == 2'h0) |-> ##1 !mod_en [*3];
   endproperty
   a_div_fast: assert property (p_div_fast) else $error("fast divisor wrong");

   property p_dec_bound;
      @(posedge clk_sys_i) disable iff (rst_i)
      dec_reg < OSR_HIRES;
   endproperty
   a_dec_bound: assert property (p_dec_bound) else $error("decimation count overrun");

   property p_hold_result;
      @(posedge clk_sys_i) disable iff (rst_i)
      (result_valid_o && !result_ready_i) |=> result_valid_o && $stable(result_o);
   endproperty
   a_hold_result: assert property (p_hold_result) else $error("result dropped under stall");

   property p_prof_follow;
      @(posedge clk_sys_i) disable iff (rst_i)
      (st_reg == ST_RUN && align_s2_reg && prof_s2_reg != prof_reg) |=> prof_reg == $past(prof_s2_reg);
   endproperty
   a_prof_follow: assert property (p_prof_follow) else $error("profile not followed");
endmodule

/* File: rtl/result_fifo.sv */
`timescale 1ns/100ps
module result_fifo #(
   parameter int WIDTH = 192,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   // Drain side
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
   logic             push, pop;

   // Pointer arithmetic with one extra wrap bit
   always_comb begin
      push    = in_valid_i && in_ready_o;
      pop     = out_valid_o && out_ready_i;
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage array
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data_i;
      end
   end

   // Full and empty flags
   assign in_ready_o  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid_o = (wr_reg != rd_reg);
   assign out_data_o  = mem[rd_reg[AW-1:0]];
endmodule

/* File: verif/result_sink.sv */
`timescale 1ns/100ps
module result_sink
   import decim_pkg::*;
(
   // Clock and reset
   input  wire logic   clk_sys_i,
   input  wire logic   rst_i,
   // Result stream
   input  wire frame_t result_i,
   input  wire logic   result_valid_i,
   output logic        result_ready_o,
   // Bench control and view
   input  wire logic   stall_i,
   output frame_t      last_o,
   output int          taken_o
);
   // Accepts when not stalled, whole frame captured at once
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         result_ready_o <= 1'b0;
         last_o         <= '0;
         taken_o        <= 0;
      end else begin
         result_ready_o <= !stall_i;
         if (result_valid_i && result_ready_o) begin
            last_o  <= result_i;
            taken_o <= taken_o + 1;
         end
      end
   end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import decim_pkg::*;
   typedef struct {
      logic [1:0] prof;
      logic       div;
      int         mod_p;
      int         word_p;
   } row_t;
   logic              clk_sys_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [1:0]        profile_select_i = 2'h0;
   logic              clock_divide_select_i = 1'b1;
   logic              align_n_i = 1'b1;
   logic [NUM_CH-1:0] mod_bits_i = 8'h00;
   frame_t            result_o;
   frame_t            last;
   logic              result_valid_o;
   logic              result_ready;
   logic              modulator_rate_o;
   logic              output_word_rate_o;
   logic              overflow_o;
   logic              stall = 1'b0;
   int                taken;
   int                failures = 0;
   int                samples_checked = 0;
   int                c;
   int                t0;
   row_t              rows [6];

   // 125 MHz clock
   always #4 clk_sys_i = ~clk_sys_i;

   octal_decimation_filter_core dut_u (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .profile_select_i(profile_select_i),
      .clock_divide_select_i(clock_divide_select_i), .align_n_i(align_n_i),
      .mod_bits_i(mod_bits_i), .result_o(result_o), .result_valid_o(result_valid_o),
      .result_ready_i(result_ready), .modulator_rate_o(modulator_rate_o),
      .output_word_rate_o(output_word_rate_o), .overflow_o(overflow_o));

   result_sink sink_u (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .result_i(result_o),
      .result_valid_i(result_valid_o), .result_ready_o(result_ready),
      .stall_i(stall), .last_o(last), .taken_o(taken));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Cycles until the next rate pulse, bounded
   task automatic wait_pulse(input logic word, input int lim, output int cnt);
      int n;
      for (n = 1; n <= lim; n++) begin
         @(negedge clk_sys_i);
         if ((word ? output_word_rate_o : modulator_rate_o) === 1'b1)
            break;
      end
      if (n > lim) begin
         failures++;
         $display("Error rate pulse expected 1 seen 0");
         summarize();
      end
      cnt = n;
   endtask

   initial begin
      // Profile, divide pin, modulator and word periods
      rows[0] = '{2'h0, 1'b1, 4, 256};
      rows[1] = '{2'h1, 1'b1, 4, 512};
      rows[2] = '{2'h2, 1'b1, 8, 512};
      rows[3] = '{2'h2, 1'b0, 4, 256};
      rows[4] = '{2'h3, 1'b1, 40, 2560};
      rows[5] = '{2'h3, 1'b0, 8, 512};
      repeat (2) @(negedge clk_sys_i);
      rst_i = 1'b0;
      foreach (rows[i]) begin
         profile_select_i      = rows[i].prof;
         clock_divide_select_i = rows[i].div;
         wait_pulse(1'b1, 6000, c);
         wait_pulse(1'b0, 100, c);
         wait_pulse(1'b0, 100, c);
         chk("modulator period", c, rows[i].mod_p);
         wait_pulse(1'b1, 3000, c);
         wait_pulse(1'b1, 3000, c);
         chk("word period", c, rows[i].word_p);
      end
      // Full scale per channel, both ratios
      for (int p = 0; p < 2; p++) begin
         profile_select_i      = p ? PROF_HIRES : PROF_FAST;
         clock_divide_select_i = 1'b1;
         mod_bits_i            = p ? 8'hAA : 8'h55;
         repeat (6) wait_pulse(1'b1, 2000, c);
         repeat (4) @(negedge clk_sys_i);
         for (int ch = 0; ch < NUM_CH; ch++)
            chk("channel clip", {8'h00, last.sample[ch]}, {8'h00, mod_bits_i[ch] ? CODE_MAX : CODE_MIN});
      end
      // Zero mean stream gives code zero
      profile_select_i = PROF_FAST;
      repeat (2) wait_pulse(1'b1, 2000, c);
      for (int k = 0; k < 64 * 6; k++) begin
         wait_pulse(1'b0, 100, c);
         mod_bits_i = ~mod_bits_i;
      end
      repeat (4) @(negedge clk_sys_i);
      for (int ch = 0; ch < NUM_CH; ch++)
         chk("channel zero", {8'h00, last.sample[ch]}, 32'h00000000);
      // Alignment low halts, release restarts
      align_n_i = 1'b0;
      repeat (10) @(negedge clk_sys_i);
      t0 = 0;
      repeat (600) begin
         @(negedge clk_sys_i);
         t0 += output_word_rate_o;
      end
      chk("words while halted", t0, 0);
      align_n_i = 1'b1;
      wait_pulse(1'b1, 400, c);
      chk("restart delay", (c >= 256 && c <= 264), 1);
      // Stalled consumer fills the buffer
      stall = 1'b1;
      repeat (7) wait_pulse(1'b1, 400, c);
      repeat (3) @(negedge clk_sys_i);
      chk("overflow early", overflow_o, 0);
      chk("valid held", result_valid_o, 1);
      repeat (5) wait_pulse(1'b1, 400, c);
      repeat (3) @(negedge clk_sys_i);
      chk("overflow set", overflow_o, 1);
      t0    = taken;
      stall = 1'b0;
      for (c = 0; c < 40; c++) begin
         @(negedge clk_sys_i);
         if (result_valid_o === 1'b0)
            break;
      end
      chk("drained", c < 40, 1);
      chk("frames drained", (taken - t0) >= 8, 1);
      // Reset in mid run clears everything
      rst_i = 1'b1;
      @(negedge clk_sys_i);
      chk("reset overflow", overflow_o, 0);
      chk("reset valid", result_valid_o, 0);
      chk("reset word", output_word_rate_o, 0);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      summarize();
   end
endmodule
